// ===== src/reader_tx_timing.sv
/*
 * Transmitter timing block: pulse width, symbol bursts, transmit wait
 * guard and Type B stop and guard insertion, with its registers on an
 * Avalon-MM slave port.
 * Assumes a frame source that hands over one symbol at a time and a
 * receiver that pulses rx_end_i at the end of each received frame.
 */
`timescale 1ns/1ps
`default_nettype none
`include "reader_tx_defs.svh"
module reader_tx_timing (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave.
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // Symbol stream from the framer.
    input  wire logic        sym_valid_i,
    input  wire logic [2:0]  sym_code_i,
    input  wire logic        sym_pulse_i,
    output logic             sym_ready_o,
    // Receiver event.
    input  wire logic        rx_end_i,
    // Transmitter drive.
    output logic             mod_o,
    output logic             burst_active_o,
    output logic             burst_level_o,
    output logic             stop_guard_o,
    output logic             tx_busy_o,
    output logic             tx_end_o
);

    // Register file.
    logic [7:0] data_pulse_width;      // Pulse width minus one.
    logic [7:0] symbol_burst_lengths;  // Both burst length codes.
    logic [7:0] tx_wait_control;       // Wait origin, unit, upper, stop.
    logic [7:0] wait_count_lower;      // Low byte of the wait count.
    logic [7:0] tx_mode;               // Coding, position, level, rate.

    // Bus slave state.
    logic       bus_ack;               // Second cycle of an access.
    logic [7:0] bus_index;             // Word index of the access.
    logic       wr_lane0;              // Write that reaches bits 7..0.

    // Decoded configuration.
    logic        miller_select;
    logic        type_b_select;
    logic [1:0]  pulse_start_position_select;
    logic        burst_level_control;
    logic [1:0]  bit_stream_frequency;
    logic [2:0]  one_symbol_burst_length;
    logic [2:0]  zero_symbol_burst_length;
    logic        wait_origin_select;
    logic        wait_unit_select;
    logic [2:0]  wait_count_upper;
    logic [10:0] guard_wait_count;
    logic [2:0]  stop_and_guard_length;
    logic [7:0]  etu_len;              // Bit period in carrier clocks.
    logic [7:0]  pulse_offset;         // Pulse start within the bit.

    // Carrier enable.
    logic [15:0] carrier_acc;
    logic        carrier_en;

    // Wait guard.
    logic [7:0]  step_cnt;             // Carriers within one wait step.
    logic [7:0]  step_len;             // Carriers per wait step.
    logic [10:0] wait_steps;           // Steps elapsed since the origin.
    logic        wait_done;
    logic        origin_event;

    // Sequencer.
    reader_tx_pkg::seq_state_type state;
    reader_tx_pkg::seq_state_type next_state;
    reader_tx_pkg::sym_code_type  sym_code;
    logic [7:0]  carrier_cnt;          // Carriers within the current bit.
    logic [8:0]  bits_left;            // Bits left in the current symbol.
    logic        bit_wrap;             // Last carrier of a bit.
    logic        sym_accept;           // Symbol taken this cycle.
    logic        sym_takes_time;       // Accepted symbol occupies bits.
    logic [8:0]  sym_bits;             // Bits that symbol occupies.
    logic        bit_start;            // Start of a data, start or stop bit.
    logic        cur_pulse;            // Accepted symbol wants a pulse.
    logic        cur_shaped;           // Accepted symbol is pulse-shaped.

    // Maps a burst length code to a number of bits.
    function automatic logic [8:0] burst_bits(input logic [2:0] code);
        case (code)
            3'h0:    burst_bits = `RTX_BURST_LEN_0;
            3'h1:    burst_bits = `RTX_BURST_LEN_1;
            3'h2:    burst_bits = `RTX_BURST_LEN_2;
            3'h3:    burst_bits = `RTX_BURST_LEN_3;
            3'h4:    burst_bits = `RTX_BURST_LEN_4;
            3'h5:    burst_bits = `RTX_BURST_LEN_5;
            3'h6:    burst_bits = `RTX_BURST_LEN_6;
            default: burst_bits = `RTX_BURST_LEN_7;
        endcase
    endfunction

    // Field decode of the stored registers.
    assign miller_select  = tx_mode[`RTX_MODE_MILLER_BIT];
    assign type_b_select  = tx_mode[`RTX_MODE_TYPE_B_BIT];
    assign pulse_start_position_select =
        tx_mode[`RTX_MODE_POS_MSB:`RTX_MODE_POS_LSB];
    assign burst_level_control = tx_mode[`RTX_MODE_LEVEL_BIT];
    assign bit_stream_frequency =
        tx_mode[`RTX_MODE_FREQ_MSB:`RTX_MODE_FREQ_LSB];
    assign one_symbol_burst_length =
        symbol_burst_lengths[`RTX_BURST_ONE_MSB:`RTX_BURST_ONE_LSB];
    assign zero_symbol_burst_length =
        symbol_burst_lengths[`RTX_BURST_ZERO_MSB:`RTX_BURST_ZERO_LSB];
    assign wait_origin_select = tx_wait_control[`RTX_WAIT_ORIGIN_BIT];
    assign wait_unit_select   = tx_wait_control[`RTX_WAIT_UNIT_BIT];
    assign wait_count_upper   =
        tx_wait_control[`RTX_WAIT_UPPER_MSB:`RTX_WAIT_UPPER_LSB]; // RQ11
    assign guard_wait_count   = {wait_count_upper, wait_count_lower}; // RQ12
    assign stop_and_guard_length =
        tx_wait_control[`RTX_STOP_MSB:`RTX_STOP_LSB];

    // The bit period halves with each step of the rate code.
    assign etu_len = `RTX_ETU_BASE_CARRIERS >> bit_stream_frequency;
    // Pulse start in quarters of the bit period.
    assign pulse_offset = 8'((10'(etu_len) *
                              10'(pulse_start_position_select)) >> 2); // RQ3

    // Bus handshake: every access takes one wait state, so the answer is
    // fixed and read data comes straight from a flip-flop.
    assign bus_index     = address_i[9:2];
    assign waitrequest_o = (read_i | write_i) & ~bus_ack;
    assign wr_lane0      = write_i & ~bus_ack & byteenable_i[0];

    // Ends every access one cycle after it starts.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (read_i | write_i) & ~bus_ack;
        end
    end

    // Register writes; an unmapped write is dropped.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            data_pulse_width     <= `RTX_RST_PULSE_WIDTH;
            symbol_burst_lengths <= `RTX_RST_BURST_LENGTHS;
            tx_wait_control      <= `RTX_RST_WAIT_CONTROL;
            wait_count_lower     <= `RTX_RST_WAIT_LOWER;
            tx_mode              <= `RTX_RST_MODE;
        end else if (wr_lane0) begin
            case (bus_index)
                `RTX_IDX_PULSE_WIDTH: data_pulse_width <= writedata_i[7:0];
                // Reserved bits 7 and 3 stay zero.
                `RTX_IDX_BURST_LENGTHS:
                    symbol_burst_lengths <= writedata_i[7:0] & `RTX_BURST_MASK;
                `RTX_IDX_WAIT_CONTROL: tx_wait_control <= writedata_i[7:0];
                `RTX_IDX_WAIT_LOWER: wait_count_lower <= writedata_i[7:0];
                `RTX_IDX_MODE: tx_mode <= writedata_i[7:0] & `RTX_MODE_MASK;
                // Unmapped or read-only writes are ignored.
                default: ;
            endcase
        end
    end

    // Read data, latched in the wait-state cycle; unmapped reads give zero.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (read_i & ~bus_ack) begin
            case (bus_index)
                `RTX_IDX_PULSE_WIDTH: readdata_o <= 32'(data_pulse_width);
                `RTX_IDX_BURST_LENGTHS:
                    readdata_o <= 32'(symbol_burst_lengths);
                `RTX_IDX_WAIT_CONTROL: readdata_o <= 32'(tx_wait_control);
                `RTX_IDX_WAIT_LOWER: readdata_o <= 32'(wait_count_lower);
                `RTX_IDX_MODE: readdata_o <= 32'(tx_mode);
                `RTX_IDX_STATUS: readdata_o <= 32'({burst_active_o, tx_busy_o,
                    wait_done});
                default: readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Carrier enable by phase accumulation: 20 MHz cannot be divided down
    // to 13.56 MHz exactly, so the enable has one cycle of jitter but the
    // right average rate.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            carrier_acc <= 16'h0000;
            carrier_en  <= 1'b0;
        end else if (carrier_acc + `RTX_CARRIER_KHZ >= `RTX_MCLK_KHZ) begin
            carrier_acc <= carrier_acc + `RTX_CARRIER_KHZ - `RTX_MCLK_KHZ;
            carrier_en  <= 1'b1;
        end else begin
            carrier_acc <= carrier_acc + `RTX_CARRIER_KHZ;
            carrier_en  <= 1'b0;
        end
    end

    // Wait step length: sixteen carriers, or half a bit period.
    assign step_len = wait_unit_select ? (etu_len >> 1)
                                       : `RTX_WAIT_STEP_CARRIERS; // RQ10
    // Origin of the wait: end of our last frame or of the last reception.
    assign origin_event = wait_origin_select ? rx_end_i : tx_end_o; // RQ9

    // Wait timer; it saturates at the programmed count, so a count that
    // software raises later extends the wait even once it is over.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            step_cnt   <= 8'h00;
            wait_steps <= 11'h7FF;
        end else if (origin_event) begin
            step_cnt   <= 8'h00;
            wait_steps <= 11'h000;
        end else if (carrier_en && wait_steps < guard_wait_count) begin
            if (step_cnt + 8'h01 >= step_len) begin
                step_cnt   <= 8'h00;
                wait_steps <= wait_steps + 11'h001;
            end else begin
                step_cnt <= step_cnt + 8'h01;
            end
        end
    end

    // A frame may start only when the wait has run out.
    assign wait_done = (wait_steps >= guard_wait_count) && !origin_event;
    // The framer may hand over a symbol at idle once the wait has
    // elapsed, and at any symbol boundary within a frame.
    always_comb begin
        case (state)
            reader_tx_pkg::ST_IDLE:  sym_ready_o = wait_done; // RQ13
            reader_tx_pkg::ST_FETCH: sym_ready_o = 1'b1;
            default:                 sym_ready_o = 1'b0;
        endcase
    end
    assign sym_accept = sym_valid_i & sym_ready_o;

    // Bits occupied by an accepted symbol; zero means it takes no time.
    always_comb begin
        case (reader_tx_pkg::sym_code_type'(sym_code_i))
            reader_tx_pkg::SYM_DATA,
            reader_tx_pkg::SYM_START,
            reader_tx_pkg::SYM_STOP:
                sym_bits = 9'h001;
            reader_tx_pkg::SYM_BURST0:
                sym_bits = burst_bits(zero_symbol_burst_length); // RQ7
            reader_tx_pkg::SYM_BURST1:
                sym_bits = burst_bits(one_symbol_burst_length); // RQ8
            reader_tx_pkg::SYM_CHAR_END:
                // Stop bit plus guard units equal the code value.
                sym_bits = type_b_select ?
                           {6'h00, stop_and_guard_length} : 9'h000; // RQ14 RQ15
            default:
                sym_bits = 9'h000;
        endcase
    end
    assign sym_takes_time = sym_accept && (sym_bits != 9'h000);

    // Sequencer transitions.
    always_comb begin
        next_state = state;
        case (state)
            reader_tx_pkg::ST_IDLE,
            reader_tx_pkg::ST_FETCH: begin
                if (sym_accept) begin
                    if (sym_code_i == 3'(reader_tx_pkg::SYM_FRAME_END)) begin
                        next_state = reader_tx_pkg::ST_IDLE;
                    end else if (sym_takes_time) begin
                        next_state = reader_tx_pkg::ST_SYMBOL;
                    end else begin
                        next_state = reader_tx_pkg::ST_FETCH;
                    end
                end
            end
            reader_tx_pkg::ST_SYMBOL: begin
                if (bit_wrap && bits_left == 9'h001) begin
                    next_state = reader_tx_pkg::ST_FETCH;
                end
            end
            default: begin
                next_state = reader_tx_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= reader_tx_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Last carrier of the bit in progress.
    assign bit_wrap = (state == reader_tx_pkg::ST_SYMBOL) && carrier_en &&
                      (carrier_cnt + 8'h01 >= etu_len);

    // Bit timing and symbol length counting.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            carrier_cnt <= 8'h00;
            bits_left   <= 9'h000;
            sym_code    <= reader_tx_pkg::SYM_DATA;
        end else if (sym_takes_time) begin
            carrier_cnt <= 8'h00;
            bits_left   <= sym_bits;
            sym_code    <= reader_tx_pkg::sym_code_type'(sym_code_i);
        end else if (bit_wrap) begin
            carrier_cnt <= 8'h00;
            bits_left   <= bits_left - 9'h001;
        end else if (carrier_en && state == reader_tx_pkg::ST_SYMBOL) begin
            carrier_cnt <= carrier_cnt + 8'h01;
        end
    end

    // Pulse request of the symbol taken; bursts and guards carry none.
    assign cur_shaped = (sym_code_i == 3'(reader_tx_pkg::SYM_DATA)) ||
                        (sym_code_i == 3'(reader_tx_pkg::SYM_START)) ||
                        (sym_code_i == 3'(reader_tx_pkg::SYM_STOP));
    assign cur_pulse  = sym_pulse_i && cur_shaped; // RQ5
    assign bit_start  = sym_takes_time && cur_shaped;

    // Width limit only under Miller coding; other codings keep the pulse
    // to the end of the bit.
    pulse_shaper u_shaper (
        .mclk_i        (mclk_i),
        .rst_n_i       (rst_n_i),
        .carrier_en_i  (carrier_en),
        .bit_start_i   (bit_start | (bit_wrap && bits_left == 9'h001)),
        .pulse_en_i    (cur_pulse & bit_start),
        .limit_width_i (miller_select), // RQ4
        .width_i       (data_pulse_width), // RQ1
        .offset_i      (pulse_offset),
        .bit_len_i     (etu_len),
        .mod_o         (mod_o)
    );

    // Registered drive levels for bursts, stop and guard, and frame end.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            burst_active_o <= 1'b0;
            burst_level_o  <= 1'b0;
            stop_guard_o   <= 1'b0;
            tx_busy_o      <= 1'b0;
            tx_end_o       <= 1'b0;
        end else begin
            burst_active_o <= (next_state == reader_tx_pkg::ST_SYMBOL) &&
                ((sym_takes_time ? sym_code_i : 3'(sym_code)) ==
                     3'(reader_tx_pkg::SYM_BURST0) ||
                 (sym_takes_time ? sym_code_i : 3'(sym_code)) ==
                     3'(reader_tx_pkg::SYM_BURST1)); // RQ6
            burst_level_o  <= burst_level_control; // RQ6
            stop_guard_o   <= (next_state == reader_tx_pkg::ST_SYMBOL) &&
                ((sym_takes_time ? sym_code_i : 3'(sym_code)) ==
                     3'(reader_tx_pkg::SYM_CHAR_END)); // RQ14
            tx_busy_o      <= (next_state != reader_tx_pkg::ST_IDLE);
            tx_end_o       <= sym_accept && (state != reader_tx_pkg::ST_IDLE) &&
                (sym_code_i == 3'(reader_tx_pkg::SYM_FRAME_END)); // RQ9
        end
    end

endmodule : reader_tx_timing
`default_nettype wire

// ===== src/reader_tx_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * transmitter timing configuration block.
 * Assumes a 20 MHz system clock and a 13.56 MHz carrier.
 */
// Summary of operation
// RQ1 - Pulse lasts programmed width plus one carriers.
// RQ2 - Pulse never runs past the bit end.
// RQ3 - Pulse start follows the start-position setting.
// RQ4 - Width applies only under Miller coding.
// RQ5 - Same width shapes start and stop symbols.
// RQ6 - Burst length from fields, level from control.
// RQ7 - Burst codes 0..7 give 8..256 bits.
// RQ8 - Symbol 1 burst uses symbol 0 mapping.
// RQ9 - Wait counts from last send or receive.
// RQ10 - Wait step: 16 carriers or half bit.
// RQ11 - Control bits 5..3 are wait upper bits.
// RQ12 - Wait count is eleven bits wide.
// RQ13 - No transmission before the wait elapses.
// RQ14 - Stop code picks stop bit and guard units.
// RQ15 - Stop and guard only under Type B.
`ifndef READER_TX_DEFS_SVH
`define READER_TX_DEFS_SVH

// Register indices; the byte address is four times the index.
`define RTX_IDX_PULSE_WIDTH   8'h2F
`define RTX_IDX_BURST_LENGTHS 8'h30
`define RTX_IDX_WAIT_CONTROL  8'h31
`define RTX_IDX_WAIT_LOWER    8'h32
`define RTX_IDX_MODE          8'h38
`define RTX_IDX_STATUS        8'h39

// Reset values.
`define RTX_RST_PULSE_WIDTH   8'h00
`define RTX_RST_BURST_LENGTHS 8'h00
`define RTX_RST_WAIT_CONTROL  8'hC0
`define RTX_RST_WAIT_LOWER    8'h00
`define RTX_RST_MODE          8'h00

// Burst length register fields.
`define RTX_BURST_ONE_MSB     6
`define RTX_BURST_ONE_LSB     4
`define RTX_BURST_ZERO_MSB    2
`define RTX_BURST_ZERO_LSB    0
`define RTX_BURST_MASK        8'h77

// Wait control register fields.
`define RTX_WAIT_ORIGIN_BIT   7
`define RTX_WAIT_UNIT_BIT     6
`define RTX_WAIT_UPPER_MSB    5
`define RTX_WAIT_UPPER_LSB    3
`define RTX_STOP_MSB          2
`define RTX_STOP_LSB          0

// Mode register fields.
`define RTX_MODE_MILLER_BIT   0
`define RTX_MODE_TYPE_B_BIT   1
`define RTX_MODE_POS_MSB      3
`define RTX_MODE_POS_LSB      2
`define RTX_MODE_LEVEL_BIT    4
`define RTX_MODE_FREQ_MSB     6
`define RTX_MODE_FREQ_LSB     5
`define RTX_MODE_MASK         8'h7F

// Carrier enable from the system clock, rates in kHz.
`define RTX_CARRIER_KHZ       16'd13560
`define RTX_MCLK_KHZ          16'd20000

// Wait step and bit period, in carrier clocks.
`define RTX_WAIT_STEP_CARRIERS 8'd16
`define RTX_ETU_BASE_CARRIERS  8'd128

// Burst lengths in bits for codes 0 to 7.
`define RTX_BURST_LEN_0       9'd8
`define RTX_BURST_LEN_1       9'd16
`define RTX_BURST_LEN_2       9'd32
`define RTX_BURST_LEN_3       9'd48
`define RTX_BURST_LEN_4       9'd64
`define RTX_BURST_LEN_5       9'd96
`define RTX_BURST_LEN_6       9'd128
`define RTX_BURST_LEN_7       9'd256

`endif

// ===== src/reader_tx_pkg.sv
/*
 * Types of the transmitter timing configuration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package reader_tx_pkg;

    // Symbols that the frame source hands to the sequencer.
    typedef enum logic [2:0] {
        SYM_DATA      = 3'h0,
        SYM_START     = 3'h1,
        SYM_STOP      = 3'h2,
        SYM_BURST0    = 3'h3,
        SYM_BURST1    = 3'h4,
        SYM_CHAR_END  = 3'h5,
        SYM_FRAME_END = 3'h6
    } sym_code_type;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_FETCH  = 3'b010,
        ST_SYMBOL = 3'b100
    } seq_state_type;

endpackage : reader_tx_pkg

// ===== src/pulse_shaper.sv
/*
 * Shapes one modulation pulse inside one bit period.
 * Assumes bit_start_i coincides with a carrier enable boundary.
 */
`timescale 1ns/1ps
`default_nettype none
module pulse_shaper (
    // Clock and reset.
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Timing.
    input  wire logic       carrier_en_i,
    input  wire logic       bit_start_i,
    // Pulse request and shape.
    input  wire logic       pulse_en_i,
    input  wire logic       limit_width_i,
    input  wire logic [7:0] width_i,
    input  wire logic [7:0] offset_i,
    input  wire logic [7:0] bit_len_i,
    // Modulation output.
    output logic            mod_o
);

    logic [7:0] pos;       // Carrier clocks since the bit began.
    logic       armed;     // This bit carries a pulse.
    logic       active;    // Pulse window decode.

    // The position saturates at the bit length, so the window closes there
    // even when the next bit boundary comes late.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pos   <= 8'h00;
            armed <= 1'b0;
        end else if (bit_start_i) begin
            pos   <= 8'h00;
            armed <= pulse_en_i;
        end else if (carrier_en_i && pos < bit_len_i) begin
            pos <= pos + 8'h01;
        end
    end

    // Window from the offset for width plus one carriers, cut at bit end.
    always_comb begin
        active = armed && (pos >= offset_i) && (pos < bit_len_i); // RQ2 RQ3
        if (limit_width_i &&
            ({1'b0, pos} > ({1'b0, offset_i} + {1'b0, width_i}))) begin
            active = 1'b0; // RQ1
        end
    end

    // Registered so the pin never sees decode glitches.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mod_o <= 1'b0;
        end else begin
            mod_o <= active;
        end
    end

endmodule : pulse_shaper
`default_nettype wire

// ===== tb/card_model.sv
/* Card across the field: ends a reply a short or long time after a frame.
   Assumes tx_end_i is a one-cycle pulse. */
`timescale 1ns/1ps
`default_nettype none
module card_model (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic tx_end_i,
    input  wire logic slow_i,
    output logic      rx_end_o
);
    int cnt; // Cycles left before the reply ends.
    // Each frame end restarts the reply; reset drops a pending one.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) cnt <= 0;
        else if (tx_end_i) cnt <= slow_i ? 40 : 4;
        else if (cnt > 0) cnt <= cnt - 1;
        rx_end_o <= rst_n_i && cnt == 1;
    end
endmodule // card_model
`default_nettype wire

// ===== tb/tx_timing_chk.sv
/* Port checker of the timing block, bound to it.
   Assumes a single clock and synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tx_timing_chk (
    input wire logic        mclk_i, rst_n_i, read_i, waitrequest_o,
    input wire logic [9:0]  address_i,
    input wire logic [31:0] readdata_o,
    input wire logic [2:0]  sym_code_i,
    input wire logic        sym_valid_i, sym_ready_o, mod_o, tx_end_o,
    input wire logic        burst_active_o, stop_guard_o, tx_busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Every read has exactly one wait state.
    wait_one_a: assert property ($rose(read_i) |->
        waitrequest_o ##1 !waitrequest_o) else $error("bus wait");
    busy_acc_a: assert property (sym_valid_i && sym_ready_o &&
        sym_code_i < 3'h3 |=> tx_busy_o) else $error("no busy");
    busy_src_a: assert property ($rose(tx_busy_o) |->
        $past(sym_valid_i && sym_ready_o)) else $error("busy cause");
    mod_busy_a: assert property (mod_o |-> tx_busy_o)
        else $error("pulse outside bit");
    burst_mod_a: assert property (burst_active_o |->
        !mod_o && tx_busy_o) else $error("burst modulated");
    stop_busy_a: assert property (stop_guard_o |->
        tx_busy_o && !burst_active_o) else $error("stop overlap");
    rsv_read_a: assert property (read_i && !waitrequest_o &&
        address_i[9:2] == 8'h30 |-> readdata_o[31:7] == 25'h0
        && !readdata_o[3]) else $error("reserved bits");
    end_pulse_a: assert property (tx_end_o |=> !tx_end_o)
        else $error("end pulse");
    cover property ($rose(mod_o));
    cover property ($fell(burst_active_o));
    cover property ($rose(stop_guard_o));
endmodule // tx_timing_chk
bind reader_tx_timing tx_timing_chk chk_u (.*);
`default_nettype wire

// ===== tb/tb_top.sv
/* Self-checking bench of the timing block with a card model.
   Assumes a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 0, rst_n_i = 0, read_i = 0, write_i = 0, slow = 0;
    logic sym_valid_i = 0, sym_pulse_i = 0, waitrequest_o, sym_ready_o;
    logic [2:0] sym_code_i = 3'h0;
    logic [9:0] address_i = 10'h000;
    logic [31:0] writedata_i = 32'h0, readdata_o;
    logic rx_end_i, mod_o, burst_active_o, burst_level_o, stop_guard_o;
    logic tx_busy_o, tx_end_o;
    logic [7:0] q, v;
    int mismatches = 0, n_compared = 0, n;
    wire logic [3:0] obs = {!sym_ready_o, stop_guard_o, burst_active_o, mod_o};
    reader_tx_timing dut_u (.mclk_i, .rst_n_i, .address_i, .read_i,
        .write_i, .byteenable_i(4'hF), .writedata_i, .readdata_o,
        .waitrequest_o, .sym_valid_i, .sym_code_i, .sym_pulse_i,
        .sym_ready_o, .rx_end_i, .mod_o, .burst_active_o, .burst_level_o,
        .stop_guard_o, .tx_busy_o, .tx_end_o);
    card_model card_u (.mclk_i, .rst_n_i, .tx_end_i(tx_end_o),
        .slow_i(slow), .rx_end_o(rx_end_i));
    initial forever #25 mclk_i = ~mclk_i;
    // Carriers to clock cycles; the carrier tick jitters by a cycle.
    function automatic logic near(int m, int c);
        return (m - c * 20000 / 13560) inside {[-3:3]};
    endfunction
    function automatic int blen(int k);
        int t[8] = '{8, 16, 32, 48, 64, 96, 128, 256};
        return t[k];
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e, string s);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %0h got %0h", s, e, g);
        end
    endtask
    // One register access; held until waitrequest is seen low.
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge mclk_i);
        address_i <= {a, 2'b00};
        write_i <= w;
        read_i <= !w;
        writedata_i <= {24'h0, d};
        do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic send(logic [2:0] c, logic p);
        @(posedge mclk_i);
        sym_valid_i <= 1'b1; sym_code_i <= c; sym_pulse_i <= p;
        do @(posedge mclk_i); while (sym_ready_o !== 1'b1);
        sym_valid_i <= 1'b0;
    endtask
    // Length in cycles of the next high run of one observed signal.
    task automatic meas(int k);
        n = 0;
        @(negedge mclk_i);
        for (int i = 0; i < 400 && obs[k] !== 1'b1; i++) @(negedge mclk_i);
        while (obs[k] === 1'b1) begin n++; @(negedge mclk_i); end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge mclk_i);
        mismatches++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hB3E1));
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'h2F + i, 8'h00);
            chk(q, i == 2 ? 8'hC0 : 8'h00, "reset");
            v = $urandom;
            bus(1, 8'h2F + i, v);
            bus(0, 8'h2F + i, 8'h00);
            chk(q, i == 1 ? v & 8'h77 : v, "readback");
        end
        bus(1, 8'h40, 8'h5A);
        bus(0, 8'h40, 8'h00);
        chk(q, 8'h00, "unmapped");
        bus(1, 8'h31, 8'h00);
        bus(1, 8'h32, 8'h00);
        bus(1, 8'h38, 8'h01);
        for (int i = 0; i < 3; i++) begin
            v = i == 0 ? 8'h00 : i == 1 ? 8'(1 + $urandom % 90) : 8'hFF;
            bus(1, 8'h2F, v);
            send(i == 1 ? 3'h1 : 3'h0, 1'b1);
            meas(0);
            chk(near(n, v > 127 ? 128 : v + 1), 1, "width");
        end
        bus(1, 8'h2F, 8'h03);
        bus(1, 8'h38, 8'h08);
        send(3'h0, 1'b1);
        meas(0);
        chk(near(n, 64), 1, "start");
        bus(1, 8'h38, 8'h70);
        for (int k = 0; k < 8; k++) begin
            bus(1, 8'h30, 8'((7 - k) * 16 + k));
            send(3'h3, 1'b0);
            meas(1);
            chk(near(n, blen(k) * 16), 1, "burst0");
            send(3'h4, 1'b0);
            meas(1);
            chk(near(n, blen(7 - k) * 16), 1, "burst1");
        end
        chk(burst_level_o, 1, "level");
        bus(1, 8'h38, 8'h62);
        for (int k = 0; k < 9; k++) begin
            if (k == 8) bus(1, 8'h38, 8'h60);
            bus(1, 8'h31, 8'(k == 8 ? 7 : k));
            send(3'h5, 1'b0);
            meas(2);
            chk(near(n, k == 8 ? 0 : k * 16), 1, "stop");
        end
        bus(1, 8'h32, 8'h05);
        bus(1, 8'h31, 8'h08);
        send(3'h6, 1'b0);
        meas(3);
        chk(near(n, 261 * 16), 1, "tx wait");
        slow <= 1'($urandom);
        bus(1, 8'h32, 8'h20);
        bus(1, 8'h31, 8'hC0);
        send(3'h0, 1'b0);
        send(3'h6, 1'b0);
        meas(3);
        chk(near(n, 32 * 8), 1, "rx wait");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
